// ==== hdl/pssb_pkg.sv ====
// How it works
// - Soft-start held discharged until line, bias and reference are good, then charges.
// - No primary pulses until soft-start passes its offset; then it sets duty.
// - Pulse ends when ramp exceeds lower of soft-start and error levels.
// - Forcing soft-start low collapses duty; release starts a fresh soft-start.
// - Phase A: high_drive_a with low_drive_b, then both high sides freewheel.
// - Phase B: high_drive_b with low_drive_a, then both low sides freewheel.
// - First setting gaps freewheel to active; second gaps active to freewheel.
// - No error current means the pulse runs to the maximum duty.
// - A fixed 30 ns minimum dead-time always applies.
// - Each leg A output's duty is capped at (period minus first gap) over two periods.
// - During the A diagonal transfer rectifier_a is on and rectifier_b off.
// - Opposite rectifier turns on a fixed 30 ns after a transfer pulse ends.
// - In steady freewheel both rectifier outputs are on.
// - At oscillator edge rectifier_a drops with high_drive_a, rectifier_b with low_drive_a.
// - Dead-time equals setting times 3 pF, setting valid 20k to 100k.
// - Only the first setting limits maximum duty.
// - Rectifier ramp held discharged until soft-start passes 2 V and error loop controls.
// - Rectifiers stay off until their ramp passes 1 V, then leading edge widens.
// - In rectifier soft-start both pulse late in freewheel; edge keeps the in-phase one.
// - In-phase rectifier held through transfer, dropped with the primary outputs.
// - Forcing the rectifier ramp low keeps both rectifier outputs off.
// - Hard faults drive every control output low at once.
`default_nettype none
package pssb_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MIN_GAP_NS    = 30;
  localparam int SR_ON_GAP_NS  = 30;
  localparam int GAP_SCALE_PF  = 3;
  localparam int SET_MIN_KOHM  = 20;
  localparam int SET_MAX_KOHM  = 100;
  localparam int SET_W         = 7;
  localparam int TMR_W         = 8;
  localparam int MIN_GAP_CYC   = (MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_ON_GAP_CYC = (SR_ON_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bridge sequencing states, Gray coded from IDLE through FREE; the FREE to PA step changes three bits.
  typedef enum logic [2:0] {
    PSSB_IDLE = 3'h0,
    PSSB_PA   = 3'h1,
    PSSB_ACT  = 3'h3,
    PSSB_AP   = 3'h2,
    PSSB_FREE = 3'h6
  } pssb_state_t;

  // Comparator and supply indications from the analog front end.
  typedef struct packed {
    logic line_ok;
    logic bias_ok;
    logic ref_ok;
    logic hard_fault;
    logic osc_clk;
    logic ss_above_offset;
    logic ss_above_2v;
    logic comp_in_control;
    logic ss_forced_low;
    logic ramp_above_ss;
    logic ramp_above_err;
    logic rectifier_ramp_level_above_1v;
    logic rectifier_ramp_level_forced_low;
    logic sr_window;
  } pssb_sense_t;

  // Gate and rectifier control outputs.
  typedef struct packed {
    logic high_drive_a;
    logic high_drive_b;
    logic low_drive_a;
    logic low_drive_b;
    logic rectifier_a;
    logic rectifier_b;
  } pssb_drive_t;

  // Converts a setting in kilohms to a gap in clock cycles, never below the minimum.
  function automatic logic [TMR_W-1:0] pssb_gap_cycles(input logic [SET_W-1:0] kohm);
    int k;
    int cyc;
    k = int'(kohm);
    if (k > SET_MAX_KOHM) begin
      k = SET_MAX_KOHM;
    end else if (k != 0 && k < SET_MIN_KOHM) begin
      k = SET_MIN_KOHM;
    end
    cyc = (k * GAP_SCALE_PF + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cyc < MIN_GAP_CYC) begin
      cyc = MIN_GAP_CYC;
    end
    return cyc[TMR_W-1:0];
  endfunction
endpackage

`timescale 1ns/1ps
// Two-flop synchroniser for pin-level inputs.
module pssb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pssb_sync_state_t;

  pssb_sync_state_t q_ff;
  pssb_sync_state_t nxt_q;

  if (WIDTH < 1) begin : g_chk
    $error("pssb_sync needs a width of at least one");
  end

  // First stage feeds only the second stage.
  always_comb begin
    nxt_q.s1 = async_in;
    nxt_q.s2 = q_ff.s1;
  end

  // Synchronous reset to all zero.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sync_out = q_ff.s2;
endmodule
`default_nettype wire

// ==== hdl/pssb_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Phase-shifted full-bridge gate and rectifier sequencer.
module pssb_sequencer #(
  parameter int SETTING_W = pssb_pkg::SET_W
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire pssb_pkg::pssb_sense_t    sense_in,
  input  wire logic [SETTING_W-1:0]     first_gap_setting,
  input  wire logic [SETTING_W-1:0]     second_gap_setting,
  output pssb_pkg::pssb_drive_t         drive_out,
  output logic                          ss_discharge,
  output logic                          rectifier_ramp_discharge
);
  localparam int SENSE_W = $bits(pssb_pkg::pssb_sense_t);
  localparam int SYNC_W  = SENSE_W + 2 * SETTING_W;

  if (SETTING_W != pssb_pkg::SET_W) begin : g_chk_w
    $error("pssb_sequencer setting width must match the gap function");
  end
  if (((pssb_pkg::SET_MAX_KOHM * pssb_pkg::GAP_SCALE_PF) / pssb_pkg::CLK_PERIOD_NS)
      >= (1 << pssb_pkg::TMR_W)) begin : g_chk_t
    $error("pssb_sequencer gap timer too narrow");
  end

  typedef struct packed {
    pssb_pkg::pssb_state_t        st;
    logic                         phase_b;
    logic [pssb_pkg::TMR_W-1:0]   tmr;
    logic [pssb_pkg::TMR_W-1:0]   sr_tmr;
    logic                         osc_prev;
    logic                         from_free;
    logic                         sr_steady;
    logic                         sr_released;
    logic                         ss_dis;
    logic                         sr_dis;
    pssb_pkg::pssb_drive_t        drv;
  } pssb_seq_state_t;

  pssb_seq_state_t             q_ff;
  pssb_seq_state_t             nxt_q;
  pssb_pkg::pssb_sense_t       s;
  logic [SETTING_W-1:0]        set1;
  logic [SETTING_W-1:0]        set2;
  logic [SYNC_W-1:0]           sync_bus;
  logic                        osc_edge;
  logic                        stop;
  logic                        pwm_ok;
  logic                        pulse_end;
  logic                        sr_ok;
  logic [pssb_pkg::TMR_W-1:0]  gap1;
  logic [pssb_pkg::TMR_W-1:0]  gap2;

  // Every sense and setting input is brought into the clock domain first; reset is not synchronised.
  pssb_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({sense_in, first_gap_setting, second_gap_setting}),
    .sync_out (sync_bus)
  );

  // Unpack the synchronised bus and derive shared conditions.
  assign s         = pssb_pkg::pssb_sense_t'(sync_bus[SYNC_W-1 -: SENSE_W]);
  assign set1      = sync_bus[2*SETTING_W-1 -: SETTING_W];
  assign set2      = sync_bus[SETTING_W-1:0];
  assign gap1      = pssb_pkg::pssb_gap_cycles(set1);
  assign gap2      = pssb_pkg::pssb_gap_cycles(set2);
  assign osc_edge  = s.osc_clk & ~q_ff.osc_prev;
  assign stop      = ~(s.line_ok & s.bias_ok & s.ref_ok) | s.hard_fault;
  assign pwm_ok    = ~stop & ~q_ff.ss_dis & s.ss_above_offset
                     & ~s.ss_forced_low;
  assign pulse_end = s.ramp_above_ss | s.ramp_above_err;
  assign sr_ok     = ~q_ff.sr_dis & s.rectifier_ramp_level_above_1v & ~s.rectifier_ramp_level_forced_low;

  // Next-state logic for sequencing, soft-start holds and outputs.
  always_comb begin
    logic ip_q;
    logic ot_q;
    logic ip_n;
    logic ot_n;
    logic open;
    ip_q = 1'b0;
    ot_q = 1'b0;
    ip_n = 1'b0;
    ot_n = 1'b0;
    open = 1'b0;
    nxt_q = q_ff;
    nxt_q.osc_prev = s.osc_clk;
    nxt_q.ss_dis = stop;
    if (q_ff.tmr != '0) begin
      nxt_q.tmr = q_ff.tmr - 1'b1;
    end
    if (q_ff.sr_tmr != '0) begin
      nxt_q.sr_tmr = q_ff.sr_tmr - 1'b1;
    end
    // Rectifier ramp release latch.
    if (stop || s.ss_forced_low) begin
      nxt_q.sr_released = 1'b0;
    end else if (s.ss_above_2v && s.comp_in_control) begin
      nxt_q.sr_released = 1'b1;
    end
    nxt_q.sr_dis = ~nxt_q.sr_released;
    if (!sr_ok) begin
      nxt_q.sr_steady = 1'b0;
    end
    // Bridge state machine; a new oscillator period wins over gap timing.
    case (q_ff.st)
      pssb_pkg::PSSB_IDLE: begin
        if (osc_edge) begin
          nxt_q.st = pssb_pkg::PSSB_PA;
          nxt_q.phase_b = 1'b0;
          nxt_q.tmr = gap1;
          nxt_q.from_free = 1'b0;
        end
      end
      pssb_pkg::PSSB_PA: begin
        if (osc_edge) begin
          nxt_q.phase_b = ~q_ff.phase_b;
          nxt_q.tmr = gap1;
          nxt_q.from_free = 1'b0;
        end else if (q_ff.tmr == '0) begin
          nxt_q.st = pulse_end ? pssb_pkg::PSSB_AP : pssb_pkg::PSSB_ACT;
          if (pulse_end) begin
            nxt_q.tmr = gap2;
            nxt_q.sr_tmr = pssb_pkg::TMR_W'(pssb_pkg::SR_ON_GAP_CYC);
            nxt_q.sr_steady = s.sr_window & sr_ok;
          end
        end
      end
      default: begin
        if (osc_edge) begin
          nxt_q.st = pssb_pkg::PSSB_PA;
          nxt_q.phase_b = ~q_ff.phase_b;
          nxt_q.tmr = gap1;
          nxt_q.from_free = (q_ff.st == pssb_pkg::PSSB_FREE);
        end else if (q_ff.st == pssb_pkg::PSSB_ACT && pulse_end) begin
          nxt_q.st = pssb_pkg::PSSB_AP;
          nxt_q.tmr = gap2;
          nxt_q.sr_tmr = pssb_pkg::TMR_W'(pssb_pkg::SR_ON_GAP_CYC);
          nxt_q.sr_steady = s.sr_window & sr_ok;
        end else if (q_ff.st == pssb_pkg::PSSB_AP && q_ff.tmr == '0) begin
          nxt_q.st = pssb_pkg::PSSB_FREE;
        end
      end
    endcase
    if (!pwm_ok) begin
      nxt_q.st = pssb_pkg::PSSB_IDLE;
    end
    // Primary gate pattern for the next state.
    nxt_q.drv = '0;
    case (nxt_q.st)
      pssb_pkg::PSSB_PA: begin
        nxt_q.drv.low_drive_b = ~nxt_q.phase_b & nxt_q.from_free;
        nxt_q.drv.high_drive_b = nxt_q.phase_b & nxt_q.from_free;
      end
      pssb_pkg::PSSB_ACT: begin
        nxt_q.drv.high_drive_a = ~nxt_q.phase_b;
        nxt_q.drv.low_drive_b = ~nxt_q.phase_b;
        nxt_q.drv.high_drive_b = nxt_q.phase_b;
        nxt_q.drv.low_drive_a = nxt_q.phase_b;
      end
      pssb_pkg::PSSB_AP: begin
        nxt_q.drv.high_drive_a = ~nxt_q.phase_b;
        nxt_q.drv.low_drive_a = nxt_q.phase_b;
      end
      pssb_pkg::PSSB_FREE: begin
        nxt_q.drv.high_drive_a = ~nxt_q.phase_b;
        nxt_q.drv.high_drive_b = ~nxt_q.phase_b;
        nxt_q.drv.low_drive_a = nxt_q.phase_b;
        nxt_q.drv.low_drive_b = nxt_q.phase_b;
      end
      default: begin
      end
    endcase
    // Rectifier pattern: in-phase follows the next transfer, other is its partner.
    ip_q = nxt_q.phase_b ? q_ff.drv.rectifier_b : q_ff.drv.rectifier_a;
    ot_q = nxt_q.phase_b ? q_ff.drv.rectifier_a : q_ff.drv.rectifier_b;
    open = (q_ff.sr_tmr == '0) & (nxt_q.sr_steady | s.sr_window);
    case (nxt_q.st)
      pssb_pkg::PSSB_PA: begin
        ip_n = nxt_q.from_free & ip_q;
      end
      pssb_pkg::PSSB_ACT: begin
        ip_n = ip_q | q_ff.sr_steady;
      end
      pssb_pkg::PSSB_AP, pssb_pkg::PSSB_FREE: begin
        if (q_ff.st == pssb_pkg::PSSB_AP || q_ff.st == pssb_pkg::PSSB_FREE) begin
          ip_n = ip_q | open;
          ot_n = ot_q | open;
        end else begin
          ip_n = nxt_q.sr_steady & ip_q;
        end
      end
      default: begin
      end
    endcase
    if (!sr_ok) begin
      ip_n = 1'b0;
      ot_n = 1'b0;
    end
    nxt_q.drv.rectifier_a = nxt_q.phase_b ? ot_n : ip_n;
    nxt_q.drv.rectifier_b = nxt_q.phase_b ? ip_n : ot_n;
  end

  // State register with synchronous reset; both soft-start nodes held discharged.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q_ff <= '0;
      q_ff.st <= pssb_pkg::PSSB_IDLE;
      q_ff.ss_dis <= 1'b1;
      q_ff.sr_dis <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign drive_out = q_ff.drv;
  assign ss_discharge = q_ff.ss_dis;
  assign rectifier_ramp_discharge = q_ff.sr_dis;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Soft-start stays discharged while supplies are not good.
  ss_hold_a: assert property (stop |=> ss_discharge)
    else $error("soft-start not held during bad supply");

  // No diagonal transfer without soft-start past its offset.
  no_pulse_a: assert property (
      !s.ss_above_offset |=>
      !(drive_out.high_drive_a && drive_out.low_drive_b) &&
      !(drive_out.high_drive_b && drive_out.low_drive_a))
    else $error("primary pulse before soft-start offset");

  // Forced-low soft-start collapses all primary outputs.
  ss_forced_a: assert property (
      s.ss_forced_low |=>
      !drive_out.high_drive_a && !drive_out.high_drive_b &&
      !drive_out.low_drive_a && !drive_out.low_drive_b)
    else $error("primary output while soft-start forced low");

  // A hard fault leaves every control output low.
  hard_stop_a: assert property (s.hard_fault |=> drive_out == '0)
    else $error("output active during hard fault");

  // Low side of leg A stays off for the minimum gap before high side A rises.
  leg_gap_a: assert property (
      $fell(drive_out.low_drive_a) |-> !drive_out.high_drive_a [*6])
    else $error("leg A gap shorter than minimum");

  // A new period never starts with a transfer already on.
  edge_cap_a: assert property (
      osc_edge |=>
      !(drive_out.high_drive_a && drive_out.low_drive_b) &&
      !(drive_out.high_drive_b && drive_out.low_drive_a))
    else $error("transfer active at period start");

  // Opposite rectifier waits its fixed gap after the A transfer ends.
  sr_on_gap_a: assert property (
      $fell(drive_out.low_drive_b) && drive_out.high_drive_a |->
      !drive_out.rectifier_b [*6])
    else $error("rectifier on gap too short");

  // During the A transfer only rectifier_a may conduct.
  diag_sr_a: assert property (
      drive_out.high_drive_a && drive_out.low_drive_b |-> !drive_out.rectifier_b)
    else $error("rectifier_b on during A transfer");

  // Rectifier_a drops at the edge that drops high_drive_a.
  sr_edge_a: assert property (
      osc_edge && pwm_ok && !q_ff.phase_b && q_ff.st == pssb_pkg::PSSB_FREE |=>
      !drive_out.rectifier_a && !drive_out.high_drive_a)
    else $error("rectifier_a not dropped with high side");

  // Rectifier ramp releases only once soft-start and loop are in control.
  sr_release_a: assert property (
      $fell(rectifier_ramp_discharge) |-> $past(s.ss_above_2v) && $past(s.comp_in_control))
    else $error("rectifier ramp released early");

  // Forced-low rectifier ramp keeps both rectifier outputs off.
  sr_forced_a: assert property (
      s.rectifier_ramp_level_forced_low |=> !drive_out.rectifier_a && !drive_out.rectifier_b)
    else $error("rectifier on while ramp forced low");

  // Neither leg ever has both of its switches on, in any state.
  leg_shoot_a: assert property (
      !(drive_out.high_drive_a && drive_out.low_drive_a) &&
      !(drive_out.high_drive_b && drive_out.low_drive_b))
    else $error("both switches of one leg on");

  // Freewheel after the A transfer only follows at least the minimum active-to-freewheel gap.
  ap_gap_a: assert property (
      $rose(drive_out.high_drive_b) && drive_out.high_drive_a |->
      !$past(drive_out.low_drive_b, 6))
    else $error("freewheel entered too soon after transfer");

  // Steady freewheel keeps both rectifier outputs on.
  free_sr_a: assert property (
      q_ff.st == pssb_pkg::PSSB_FREE && q_ff.sr_steady |->
      drive_out.rectifier_a && drive_out.rectifier_b)
    else $error("rectifier off during steady freewheel");

  // In rectifier soft-start the in-phase output drops with the A transfer.
  sr_drop_a: assert property (
      $fell(drive_out.low_drive_b) && drive_out.high_drive_a && !q_ff.sr_steady |->
      !drive_out.rectifier_a)
    else $error("in-phase rectifier held past soft-start transfer");
endmodule
`default_nettype wire

// ==== verif/pssb_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Front-end stand-in: oscillator, modulation ramp comparators and rectifier window.
module pssb_front_model #(
  parameter int PERIOD = 120
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] ss_lvl,
  input  wire logic [7:0] err_lvl,
  input  wire logic       win_en,
  output logic            osc_clk,
  output logic            ramp_above_ss,
  output logic            ramp_above_err,
  output logic            sr_window
);
  int cnt;

  // The ramp restarts on every oscillator rising edge, so one count serves both.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || cnt == PERIOD - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Comparator outputs follow the ramp; the window opens late unless steady running is asked.
  assign osc_clk        = (cnt < PERIOD / 2);
  assign ramp_above_ss  = (cnt >= int'(ss_lvl));
  assign ramp_above_err = (cnt >= int'(err_lvl));
  assign sr_window      = win_en || (cnt >= PERIOD - 8);
endmodule
`default_nettype wire

// ==== verif/phase_shift_bridge_sequencer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the bridge sequencer driven through a front-end stand-in.
module phase_shift_bridge_sequencer_bench;
  localparam int P = 120;
  logic                  sys_clk;
  logic                  rst_n;
  logic                  line_ok, bias_ok, ref_ok, fault, ss_off, ss2v, comp;
  logic                  ss_force, sssr1v, rectifier_ramp_level_force, win_en;
  logic [6:0]            gap1, gap2;
  logic [7:0]            ss_lvl, err_lvl, seed;
  logic                  osc, r_ss, r_err, sr_win, ss_dis, rr_dis;
  logic [5:0]            dv, pv;
  logic [6:0]            tbl [6] = '{7'h00, 7'h0A, 7'h14, 7'h25, 7'h64, 7'h7F};
  pssb_pkg::pssb_sense_t sense;
  pssb_pkg::pssb_drive_t drv;
  int                    err_total = 0;
  int                    check_count = 0;
  int                    cyc = 0;
  int                    t0, t1, t2, n;

  // Sense bundle in declaration order, most significant first.
  assign sense = {line_ok, bias_ok, ref_ok, fault, osc, ss_off, ss2v, comp, ss_force,
                  r_ss, r_err, sssr1v, rectifier_ramp_level_force, sr_win};
  assign dv = drv;

  pssb_front_model #(.PERIOD(P)) i_pssb_front_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .ss_lvl(ss_lvl), .err_lvl(err_lvl), .win_en(win_en), .osc_clk(osc),
    .ramp_above_ss(r_ss), .ramp_above_err(r_err), .sr_window(sr_win));
  pssb_sequencer i_pssb_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .sense_in(sense),
    .first_gap_setting(gap1), .second_gap_setting(gap2), .drive_out(drv),
    .ss_discharge(ss_dis), .rectifier_ramp_discharge(rr_dis));

  // Clock generation and a free cycle count for edge timing.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  // Gap in cycles expected from a setting, with clamping and the fixed minimum.
  function automatic int exp_gap(input int k);
    int c;
    if (k > 100) begin
      k = 100;
    end else if (k != 0 && k < 20) begin
      k = 20;
    end
    c = (k * 3 + 4) / 5;
    return (c < 6) ? 6 : c;
  endfunction

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Waits for one output bit to move to a level and returns that cycle number.
  task automatic wait_to(input int idx, input logic lvl, output int t);
    logic p;
    int   i;
    p = dv[idx];
    t = -1;
    i = 0;
    while (t < 0 && i < 4 * P) begin
      step(1);
      if (dv[idx] === lvl && p !== lvl) begin
        t = cyc;
      end
      p = dv[idx];
      i++;
    end
    if (t < 0) begin
      chk("edge wait", 0, 1);
    end
  endtask

  // Counts cycles over two oscillator periods in which any masked output is high.
  task automatic count_hi(input logic [5:0] mask, output int c);
    c = 0;
    repeat (2 * P) begin
      step(1);
      if ((dv & mask) != 6'h00) c++;
    end
  endtask

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cycle watch on diagonal transfers and on oscillator-edge turn-offs.
  always @(posedge sys_clk) begin
    #2;
    if (rst_n && dv[5] && dv[2]) chk("rect_b in A transfer", dv[0], 0);
    if (rst_n && dv[4] && dv[3]) chk("rect_a in B transfer", dv[1], 0);
    if (pv[5] === 1'b1 && !dv[5]) chk("rect_a at high_a off", dv[1], 0);
    if (pv[3] === 1'b1 && !dv[3]) chk("rect_b at low_a off", dv[0], 0);
    pv = dv;
  end

  // Hang guard sized well beyond the expected run.
  initial begin
    #(60000 * 5);
    err_total++;
    wrap_up;
  end

  // Main sequence: reset, supplies, maximum duty, pulse ending, soft-starts, faults.
  initial begin
    {line_ok, bias_ok, ref_ok, fault, ss_off, ss2v, comp} = 7'h00;
    {ss_force, sssr1v, rectifier_ramp_level_force} = 3'h0;
    win_en = 1'b1;
    gap1 = 7'h00;
    gap2 = 7'h00;
    ss_lvl = 8'hFF;
    err_lvl = 8'hFF;
    seed = 8'h58;
    rst_n = 1'b0;
    step(4);
    chk("drive at reset", dv, 0);
    chk("ss hold at reset", ss_dis, 1);
    chk("sr ramp hold at reset", rr_dis, 1);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {line_ok, bias_ok, ref_ok} = ~(3'h4 >> i);
      step(6);
      chk("ss hold with a supply low", ss_dis, 1);
    end
    {line_ok, bias_ok, ref_ok} = 3'h7;
    step(6);
    chk("ss release", ss_dis, 0);
    count_hi(6'h3C, n);
    chk("primaries below offset", n, 0);
    ss_off = 1'b1;
    for (int i = 0; i < 9; i++) begin
      gap1 = (i < 6) ? tbl[i] : seed[6:0];
      gap2 = seed[6:0] ^ 7'h55;
      seed = lfsr(seed);
      step(3 * P);
      wait_to(3, 1'b0, t0);
      wait_to(5, 1'b1, t1);
      chk("gap before transfer", t1 - t0, exp_gap(gap1) + 1);
      chk("low_b with high_a", dv[2], 1);
      count_hi(6'h20, n);
      chk("max duty of high_a", n, P - exp_gap(gap1) - 1);
    end
    ss2v = 1'b1;
    step(6);
    chk("sr ramp held without loop control", rr_dis, 1);
    comp = 1'b1;
    sssr1v = 1'b1;
    step(6);
    chk("sr ramp release", rr_dis, 0);
    gap1 = 7'h14;
    for (int i = 0; i < 6; i++) begin
      ss_lvl = 8'h1E + {4'h0, seed[3:0]};
      err_lvl = 8'h1E + {4'h0, seed[7:4]};
      gap2 = 7'h14 + {1'b0, seed[5:0]};
      win_en = i[0];
      seed = lfsr(seed);
      step(3 * P);
      wait_to(3, 1'b0, t0);
      wait_to(2, 1'b0, t1);
      chk("transfer length", t1 - t0, (ss_lvl < err_lvl) ? ss_lvl : err_lvl);
      chk("in-phase rect at pulse end", dv[1], win_en);
      if (win_en) begin
        wait_to(0, 1'b1, t2);
        chk("rect_b on gap", (t2 - t1 >= 6 && t2 - t1 <= 8), 1);
      end
      wait_to(4, 1'b1, t2);
      chk("gap before freewheel", t2 - t1, exp_gap(gap2) + 1);
      chk("high_a in freewheel", dv[5], 1);
      step(1);
      chk("rects in freewheel", dv[1:0], {win_en, win_en});
      wait_to(3, 1'b1, t2);
      chk("high_b with low_a", dv[4], 1);
      wait_to(2, 1'b1, t2);
      chk("low side freewheel", dv[5:2], 4'h3);
    end
    win_en = 1'b0;
    count_hi(6'h03, n);
    chk("narrow rect pulses", n != 0, 1);
    sssr1v = 1'b0;
    step(3 * P);
    count_hi(6'h03, n);
    chk("rects before sr threshold", n, 0);
    sssr1v = 1'b1;
    rectifier_ramp_level_force = 1'b1;
    step(6);
    count_hi(6'h03, n);
    chk("rects with sr ramp forced", n, 0);
    rectifier_ramp_level_force = 1'b0;
    ss_force = 1'b1;
    step(6);
    count_hi(6'h3C, n);
    chk("primaries with ss forced", n, 0);
    ss_force = 1'b0;
    step(3 * P);
    count_hi(6'h3C, n);
    chk("primaries after ss release", n != 0, 1);
    fault = 1'b1;
    step(4);
    chk("drive on fault", dv, 0);
    chk("ss hold on fault", ss_dis, 1);
    wrap_up;
  end
endmodule
`default_nettype wire
